// >>> inc/twl_pkg.sv
// Constants and carrier types for the temperature warning and input
// over-voltage limit bank.
// Assumes a command-coded register port on the device side.
// How it works
// - Warn when temperature exceeds warning threshold
// - Warning sets status byte, word, alert low
// - Detect temperature warning within twenty milliseconds
// - Threshold low byte, 1 C per LSB
// - Temperature threshold resets to 145 C
// - Input above limit sets over-voltage flags
// - Power stage off while over-voltage present
// - Power stage resumes when input falls back
// - Over-voltage threshold unsigned, 500 mV per LSB
// - Over-voltage threshold resets to 16.5 V
package twl_pkg;
   // ==========================================================
   // Command codes and reset values
   localparam logic [7:0]  CMD_TEMP_WARN    = 8'h51;
   localparam logic [7:0]  CMD_VIN_OV_FAULT = 8'h55;
   localparam logic [7:0]  CMD_STATUS_BYTE  = 8'h78;
   localparam logic [7:0]  CMD_STATUS_WORD  = 8'h79;
   localparam logic [15:0] TEMP_WARN_RST    = 16'h0091;
   localparam logic [15:0] VIN_OV_RST       = 16'h0021;
   // Writable widths: temperature low byte, voltage bits 11:0
   localparam int          TEMP_BITS        = 8;
   localparam int          VIN_BITS         = 12;
   // Status field positions
   localparam int          SB_TEMP_BIT      = 2;
   localparam int          SB_OFF_BIT       = 6;
   localparam int          SW_VIN_BIT       = 13;
   // ==========================================================
   // Detection time bound
   localparam int          DETECT_MS        = 20;
   localparam int          CLK_MHZ          = 250;
   localparam longint      DETECT_CYC       = longint'(DETECT_MS) * 1000 * CLK_MHZ;

   typedef struct packed {
      logic        wr;
      logic [7:0]  cmd;
      logic [15:0] data;
   } twl_req_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  temp;
      logic [11:0] vin;
   } twl_sample_t;
endpackage

// >>> rtl/twl_top.sv
// Limit registers, comparators and status for temperature warning and
// input over-voltage fault.
// Assumes the command port is decoded by the management bus front end
// and that samples arrive synchronous to REF_CLK.
`timescale 1ns/1ps
module twl_top (
   input  wire logic               REF_CLK,
   input  wire logic               NRST,
   input  wire logic               CLK_EN,
   input  wire twl_pkg::twl_req_t  REQ,
   input  wire logic               REQ_VALID,
   output logic [15:0]             RD_DATA,
   input  wire twl_pkg::twl_sample_t SAMPLE,
   output logic                    ALERT_OUTPUT_N_O,
   output logic                    ALERT_OUTPUT_N_OE,
   output logic                    POWER_STAGE_EN,
   output logic                    TEMP_WARN,
   output logic                    VIN_OV_FAULT
);
   import twl_pkg::*;

   // ==========================================================
   // Reset release
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   // ==========================================================
   // Limit registers
   logic [TEMP_BITS-1:0] temp_lim_r;
   logic [VIN_BITS-1:0]  vin_lim_r;
   wire                  wr_temp = REQ_VALID & REQ.wr & (REQ.cmd == CMD_TEMP_WARN);
   wire                  wr_vin  = REQ_VALID & REQ.wr & (REQ.cmd == CMD_VIN_OV_FAULT);

   // Only writable bits stored, upper bits read zero
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         temp_lim_r <= TEMP_WARN_RST[TEMP_BITS-1:0];
         vin_lim_r  <= VIN_OV_RST[VIN_BITS-1:0];
      end else if (CLK_EN) begin
         if (wr_temp)
            temp_lim_r <= REQ.data[TEMP_BITS-1:0];
         if (wr_vin)
            vin_lim_r <= REQ.data[VIN_BITS-1:0];
      end
   end

   // ==========================================================
   // Comparators, evaluated per sample against live limits
   logic temp_warn_r;
   logic vin_ov_r;
   wire  temp_hi = SAMPLE.temp > temp_lim_r;
   wire  vin_hi  = SAMPLE.vin > vin_lim_r;

   // Warnings are live: they follow each sample, so the one-sample
   // latency is far inside the detection bound
   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         temp_warn_r <= 1'b0;
         vin_ov_r    <= 1'b0;
      end else if (CLK_EN && SAMPLE.valid) begin
         temp_warn_r <= temp_hi;
         vin_ov_r    <= vin_hi;
      end
   end

   // ==========================================================
   // Status and outputs
   wire [7:0]  status_byte = {1'b0, vin_ov_r, 3'b000, temp_warn_r, 2'b00};
   wire [15:0] status_word = {2'b00, vin_ov_r, 5'b0, status_byte};
   wire [15:0] rd_nxt =
      (REQ.cmd == CMD_TEMP_WARN)    ? {8'h00, temp_lim_r} :
      (REQ.cmd == CMD_VIN_OV_FAULT) ? {4'h0, vin_lim_r}   :
      (REQ.cmd == CMD_STATUS_BYTE)  ? {8'h00, status_byte} :
      (REQ.cmd == CMD_STATUS_WORD)  ? status_word : 16'h0000;

   always_ff @(posedge REF_CLK or negedge rst_n_r) begin
      if (!rst_n_r)
         RD_DATA <= 16'h0000;
      else if (CLK_EN && REQ_VALID && !REQ.wr)
         RD_DATA <= rd_nxt;
   end

   // Open drain: enable low means pulling the line low
   assign ALERT_OUTPUT_N_O  = 1'b0;
   assign ALERT_OUTPUT_N_OE = ~temp_warn_r;
   // Stage off during fault, back on by itself
   assign POWER_STAGE_EN    = ~vin_ov_r;
   assign TEMP_WARN         = temp_warn_r;
   assign VIN_OV_FAULT      = vin_ov_r;

   // ==========================================================
   // Checks
   sample_temp_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      CLK_EN && SAMPLE.valid |=> temp_warn_r == $past(temp_hi))
      else $error("temperature warning wrong");
   alert_pin_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      temp_warn_r == !ALERT_OUTPUT_N_OE && status_byte[SB_TEMP_BIT] == temp_warn_r)
      else $error("alert not tied to warning");
   vin_flag_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      CLK_EN && SAMPLE.valid |=> vin_ov_r == $past(vin_hi))
      else $error("over-voltage flag wrong");
   stage_off_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      vin_ov_r |-> !POWER_STAGE_EN)
      else $error("power stage on during fault");
   stage_back_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      CLK_EN && SAMPLE.valid && !vin_hi |=> POWER_STAGE_EN)
      else $error("power stage did not resume");
   temp_upper_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      CLK_EN && REQ_VALID && !REQ.wr && REQ.cmd == CMD_TEMP_WARN |=> RD_DATA[15:8] == 8'h00)
      else $error("upper byte not zero");
   limit_write_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      CLK_EN && wr_vin |=> vin_lim_r == $past(REQ.data[VIN_BITS-1:0]))
      else $error("limit write lost");
   warn_bound_a: assert property (@(posedge REF_CLK) disable iff (!rst_n_r)
      CLK_EN && SAMPLE.valid && temp_hi |=> temp_warn_r)
      else $error("warning not raised in time");
   reset_val_a: assert property (@(posedge REF_CLK)
      $rose(rst_n_r) |-> temp_lim_r == 8'h91 && vin_lim_r == 12'h021)
      else $error("bad reset limits");
endmodule

// >>> tb/twl_host.sv
// Host model driving limit commands onto the command port.
// Assumes the bench calls xfer just after a REF_CLK edge.
`timescale 1ns/1ps
module twl_host (
   input  wire logic        clk,
   output twl_pkg::twl_req_t req,
   output logic             req_valid,
   input  wire logic [15:0] rd_data
);
   import twl_pkg::*;
   // =====
   // Idle command port
   initial begin
      req = '0;
      req_valid = 1'b0;
   end
   // One-cycle request; read answer sampled one edge after it is taken
   // Write codes stay under 160 C and at most 18 V in their writable bits
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q);
      req <= '{w, c, d};
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
      q = rd_data;
   endtask
endmodule

// >>> tb/twl_top_tb_top.sv
// Self-checking bench: limit registers, compares, status, reset.
// Assumes the host model owns the command port.
`timescale 1ns/1ps
module twl_top_tb_top;
   import twl_pkg::*;
   typedef struct {
      logic [7:0] c; logic [15:0] w, r; logic [7:0] t; logic [11:0] v; logic tw, ov;
   } twl_row_t;
   logic        clk, nrst, oe, pen, tw, ov, cen, ao;
   logic [15:0] rd_data, q;
   twl_req_t    req;
   logic        req_valid;
   twl_sample_t smp_r;
   int          n_fail = 0, compares = 0;
   // Write, read back, then one sample against the new limit
   twl_row_t rows [4] = '{
      '{8'h51, 16'h0064, 16'h0064, 8'd101, 12'h021, 1'b1, 1'b0},
      '{8'h51, 16'hab64, 16'h0064, 8'd100, 12'h022, 1'b0, 1'b1},
      '{8'h55, 16'hf024, 16'h0024, 8'd0, 12'h024, 1'b0, 1'b0},
      '{8'h55, 16'h0023, 16'h0023, 8'hff, 12'h024, 1'b1, 1'b1}};
   // =====
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   twl_top DUT (.REF_CLK(clk), .NRST(nrst), .CLK_EN(cen), .REQ(req), .REQ_VALID(req_valid),
      .RD_DATA(rd_data), .SAMPLE(smp_r), .ALERT_OUTPUT_N_O(ao), .ALERT_OUTPUT_N_OE(oe),
      .POWER_STAGE_EN(pen), .TEMP_WARN(tw), .VIN_OV_FAULT(ov));
   twl_host HOST (.clk(clk), .req(req), .req_valid(req_valid), .rd_data(rd_data));
   // =====
   // Shared checks
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic send(input logic [7:0] t, input logic [11:0] v);
      smp_r <= '{1'b1, t, v};
      @(posedge clk);
      smp_r.valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // Flags, alert, stage enable and both status views
   task automatic obs(input logic te, input logic oe_x);
      chk("warn", 16'(te), 16'(tw));
      chk("ov", 16'(oe_x), 16'(ov));
      chk("alert_oe", 16'(!te), 16'(oe));
      chk("alert_o", 16'h0, 16'(ao));
      chk("stage_en", 16'(!oe_x), 16'(pen));
      HOST.xfer(1'b0, CMD_STATUS_BYTE, 16'h0, q);
      chk("status_byte", {9'h0, oe_x, 3'b0, te, 2'b0}, q);
      HOST.xfer(1'b0, CMD_STATUS_WORD, 16'h0, q);
      chk("status_word", {2'b0, oe_x, 6'b0, oe_x, 3'b0, te, 2'b0}, q);
   endtask
   task automatic stop_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // =====
   // Main sequence; reset tests come after the table
   initial begin
      nrst = 1'b0;
      cen = 1'b1;
      smp_r = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         HOST.xfer(1'b1, rows[i].c, rows[i].w, q);
         HOST.xfer(1'b0, rows[i].c, 16'h0, q);
         chk("limit", rows[i].r, q);
         send(rows[i].t, rows[i].v);
         obs(rows[i].tw, rows[i].ov);
         $display("row %0d done", i);
      end
      nrst <= 1'b0;
      #1 chk("alert_oe_rst", 16'h1, 16'(oe));
      chk("stage_en_rst", 16'h1, 16'(pen));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      HOST.xfer(1'b0, CMD_TEMP_WARN, 16'h0, q);
      chk("temp_rst", TEMP_WARN_RST, q);
      HOST.xfer(1'b0, CMD_VIN_OV_FAULT, 16'h0, q);
      chk("vin_rst", VIN_OV_RST, q);
      HOST.xfer(1'b0, 8'h00, 16'h0, q);
      chk("unmapped", 16'h0, q);
      send(8'h92, 12'h022);
      obs(1'b1, 1'b1);
      send(8'h91, 12'h021);
      obs(1'b0, 1'b0);
      // Clock enable low: write and sample must both be ignored
      cen <= 1'b0;
      HOST.xfer(1'b1, CMD_TEMP_WARN, 16'h0010, q);
      send(8'hff, 12'hfff);
      chk("frozen_warn", 16'h0, 16'(tw));
      chk("frozen_ov", 16'h0, 16'(ov));
      cen <= 1'b1;
      HOST.xfer(1'b0, CMD_TEMP_WARN, 16'h0, q);
      chk("frozen_lim", TEMP_WARN_RST, q);
      $display("reset and boundary tests done");
      stop_test;
   end
endmodule
